// ===== core/qas_top.v
// Four-channel serial controller: host register file, port mapping,
// rate dividers and four transmit/receive pairs.
// Assumes host strobes are synchronous to clk_sys and one cycle long.
`timescale 1ns/1ps
`include "qas_regs.vh"
// Contract
// - Mask bits: rx 7..4, tx 3..0
// - Command bit 7 starts initial reset
// - Command bits 3..0 clear port errors
// - Two-bit map field routes logical to physical
// - Enable bits 7 and 3 per logical port
// - Rate field divides by two to n
// - Status one high nibble: receive data held
// - Status one low nibble: transmitter free
// - Status two high nibble: framing errors
// - Data addresses load tx, read rx
// - Control registers at codes 0..4 write; read back except code 1, which reads zero
// - Status registers read at codes 5,6
// - Logical indexing, dividers physical, map links
// - Receive-ready low while unmasked data held
// - Transmit-ready is NOR of unmasked flags
// - Frame start, LSB first, one stop; idle high
// - Hardware preset selects rate when low
module qas_top #(
   parameter BASE_DIV = `QAS_BASE_DIV
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Host bus
   input wire cs,
   input wire cmd_sel,
   input wire [2:0] addr,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] wdata,
   output reg [7:0] rdata_r,
   output reg rx_ready_irq_n,
   output reg tx_ready_irq_n,
   // Rate presets, index 3 = physical A
   input wire [3:0] hw_rate_preset_en,
   input wire [11:0] hw_rate_code,
   // Serial lines, index 3 = physical A
   input wire [3:0] serial_in,
   output reg [3:0] serial_out
);
   // ==================================================
   // Registers
   reg [7:0] mask_r;
   reg [7:0] map_r;
   reg [7:0] edab_r;
   reg [7:0] edcd_r;
   reg [3:0] clr_r;
   reg init_r;
   reg [7:0] txd_r [0:3];
   reg [3:0] txld_r;
   reg [3:0] rdtk_r;
   wire wr = cs && wr_stb;
   wire rd = cs && rd_stb;
   integer i;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mask_r <= `QAS_ZERO8;
         map_r <= `QAS_MAP_RST;
         edab_r <= `QAS_ZERO8;
         edcd_r <= `QAS_ZERO8;
         clr_r <= 4'h0;
         init_r <= 1'b0;
         txld_r <= 4'h0;
         rdtk_r <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            txd_r[i] <= 8'h00;
         end
      end else begin
         clr_r <= 4'h0;
         init_r <= 1'b0;
         txld_r <= 4'h0;
         rdtk_r <= 4'h0;
         if (init_r) begin
            mask_r <= `QAS_ZERO8;
            map_r <= `QAS_MAP_RST;
            edab_r <= `QAS_ZERO8;
            edcd_r <= `QAS_ZERO8;
         end else if (wr && !cmd_sel && !addr[2]) begin
            txd_r[addr[1:0]] <= wdata;
            txld_r[3 - addr[1:0]] <= 1'b1;
         end else if (wr && cmd_sel) begin
            case (addr)
               `QAS_A_MASK: mask_r <= wdata;
               `QAS_A_CMD: begin
                  init_r <= wdata[`QAS_CMD_INIT];
                  clr_r <= wdata[3:0];
               end
               `QAS_A_MAP: map_r <= wdata;
               `QAS_A_EDAB: edab_r <= wdata;
               `QAS_A_EDCD: edcd_r <= wdata;
               default: ;
            endcase
         end
         if (rd && !cmd_sel && !addr[2]) begin
            rdtk_r[3 - addr[1:0]] <= 1'b1;
         end
      end
   end
   // ==================================================
   // Per-port wiring; index 3 = logical/physical A
   wire [3:0] l_en = {edab_r[7], edab_r[3], edcd_r[7], edcd_r[3]};
   wire [11:0] sw_code = {edab_r[6:4], edab_r[2:0], edcd_r[6:4], edcd_r[2:0]};
   wire [3:0] avail;
   wire [3:0] free;
   wire [3:0] ferr;
   wire [3:0] oerr;
   wire [31:0] rxd;
   wire [3:0] txl;
   wire [3:0] p_en;
   reg [4:0] base_cnt_r;
   reg base_tick_r;
   reg [6:0] rate_cnt_r [0:3];
   reg [3:0] os_tick_r;
   reg [3:0] os_cnt_r [0:3];
   reg [3:0] bit_tick_r;
   // Physical port p is fed by whichever logical port maps to it
   function [1:0] who;
      input [7:0] m;
      input [1:0] p;
      integer k;
      begin
         who = 2'd0;
         for (k = 0; k < 4; k = k + 1) begin
            if (m[2 * k +: 2] == p) begin
               who = k[1:0];
            end
         end
      end
   endfunction
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         base_cnt_r <= 5'h0;
         base_tick_r <= 1'b0;
      end else begin
         base_tick_r <= 1'b0;
         base_cnt_r <= base_cnt_r + 5'h1;
         if (base_cnt_r == BASE_DIV[4:0] - 5'h1) begin
            base_cnt_r <= 5'h0;
            base_tick_r <= 1'b1;
         end
      end
   end
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : port
         // Logical g drives physical map field g
         wire [1:0] ph = map_r[2 * g +: 2];
         localparam [1:0] GI = g;
         wire [1:0] src = who(map_r, GI);
         wire [2:0] code = hw_rate_preset_en[g] ? sw_code[3 * g +: 3]
            : hw_rate_code[3 * g +: 3];
         wire [6:0] lim = (7'h01 << code) - 7'h01;
         assign p_en[g] = l_en[src];
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               rate_cnt_r[g] <= 7'h0;
               os_tick_r[g] <= 1'b0;
               os_cnt_r[g] <= 4'h0;
               bit_tick_r[g] <= 1'b0;
            end else begin
               os_tick_r[g] <= 1'b0;
               bit_tick_r[g] <= 1'b0;
               if (base_tick_r) begin
                  rate_cnt_r[g] <= rate_cnt_r[g] + 7'h1;
                  if (rate_cnt_r[g] >= lim) begin
                     rate_cnt_r[g] <= 7'h0;
                     os_tick_r[g] <= 1'b1;
                     os_cnt_r[g] <= os_cnt_r[g] + 4'h1;
                     bit_tick_r[g] <= os_cnt_r[g] == 4'hf;
                  end
               end
            end
         end
         qas_tx u_tx (
            .clk_sys(clk_sys),
            .rst(rst),
            .soft_rst(init_r),
            .enable(l_en[g]),
            .bit_tick(bit_tick_r[ph]),
            .load(txld_r[g]),
            .din(txd_r[3 - g]),
            .free_r(free[g]),
            .line_r(txl[g])
         );
         qas_rx u_rx (
            .clk_sys(clk_sys),
            .rst(rst),
            .soft_rst(init_r),
            .enable(l_en[g]),
            .os_tick(os_tick_r[ph]),
            .line_in(serial_in[ph]),
            .err_clr(clr_r[g]),
            .rd_take(rdtk_r[g]),
            .avail_r(avail[g]),
            .data_r(rxd[8 * g +: 8]),
            .ferr_r(ferr[g]),
            .oerr_r(oerr[g])
         );
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               serial_out[g] <= 1'b1;
            end else begin
               serial_out[g] <= p_en[g] ? txl[src] : 1'b1;
            end
         end
      end
   endgenerate
   // ==================================================
   // Read mux and ready pins
   wire [7:0] stat1 = {avail, free};
   wire [7:0] stat2 = {ferr, oerr};
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
         rx_ready_irq_n <= 1'b1;
         tx_ready_irq_n <= 1'b1;
      end else begin
         rx_ready_irq_n <= ~|(avail & ~mask_r[7:4]);
         tx_ready_irq_n <= ~|(free & ~mask_r[3:0]);
         if (rd) begin
            if (!cmd_sel) begin
               rdata_r <= addr[2] ? `QAS_UNUSED_RD : rxd[8 * (3 - addr[1:0]) +: 8];
            end else begin
               case (addr)
                  `QAS_A_MASK: rdata_r <= mask_r;
                  `QAS_A_CMD: rdata_r <= `QAS_ZERO8;
                  `QAS_A_MAP: rdata_r <= map_r;
                  `QAS_A_EDAB: rdata_r <= edab_r;
                  `QAS_A_EDCD: rdata_r <= edcd_r;
                  `QAS_A_STAT1: rdata_r <= stat1;
                  `QAS_A_STAT2: rdata_r <= stat2;
                  default: rdata_r <= `QAS_UNUSED_RD;
               endcase
            end
         end
      end
   end
endmodule

// ===== core/qas_regs.vh
// Constants for the four-channel asynchronous serial controller.
// Assumes inclusion by bare name from the design files.
`ifndef QAS_REGS_VH
`define QAS_REGS_VH
// ==================================================
// Address codes with command/data select high
`define QAS_A_MASK 3'h0
`define QAS_A_CMD 3'h1
`define QAS_A_MAP 3'h2
`define QAS_A_EDAB 3'h3
`define QAS_A_EDCD 3'h4
`define QAS_A_STAT1 3'h5
`define QAS_A_STAT2 3'h6
`define QAS_UNUSED_RD 8'h00
// ==================================================
// Field positions and reset values
`define QAS_CMD_INIT 7
`define QAS_MAP_RST 8'he4
`define QAS_ZERO8 8'h00
`define QAS_BASE_DIV 24
`define QAS_OVS 16
`endif

// ===== core/qas_tx.v
// Serial transmitter for one port: start, 8 data LSB first, 1 stop.
// Assumes bit_tick is a one-cycle pulse at the bit rate.
`timescale 1ns/1ps
module qas_tx (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   input wire soft_rst,
   // Control
   input wire enable,
   input wire bit_tick,
   input wire load,
   input wire [7:0] din,
   // Status and line
   output reg free_r,
   output reg line_r
);
   reg [8:0] shift_r;
   reg [3:0] cnt_r;
   reg busy_r;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         free_r <= 1'b1;
         line_r <= 1'b1;
         shift_r <= 9'h1ff;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
      end else if (soft_rst || !enable) begin
         free_r <= 1'b1;
         line_r <= 1'b1;
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
      end else begin
         if (load && free_r) begin
            shift_r <= {din, 1'b0};
            free_r <= 1'b0;
         end
         if (bit_tick) begin
            if (busy_r) begin
               line_r <= shift_r[0];
               shift_r <= {1'b1, shift_r[8:1]};
               if (cnt_r == 4'h9) begin
                  busy_r <= 1'b0;
                  free_r <= 1'b1;
                  line_r <= 1'b1;
               end
               cnt_r <= cnt_r + 4'h1;
            end else if (!free_r) begin
               busy_r <= 1'b1;
               cnt_r <= 4'h0;
               line_r <= 1'b1;
            end
         end
      end
   end
endmodule

// ===== core/qas_rx.v
// Serial receiver for one port with 16x oversampling, mid-bit sample.
// Assumes os_tick pulses at sixteen times the bit rate.
`timescale 1ns/1ps
`include "qas_regs.vh"
module qas_rx (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   input wire soft_rst,
   // Control
   input wire enable,
   input wire os_tick,
   input wire line_in,
   input wire err_clr,
   input wire rd_take,
   // Results
   output reg avail_r,
   output reg [7:0] data_r,
   output reg ferr_r,
   output reg oerr_r
);
   localparam IDLE = 3'b001;
   localparam BITS = 3'b010;
   localparam STOP = 3'b100;
   reg [2:0] st_r;
   reg [3:0] ph_r;
   reg [3:0] cnt_r;
   reg [7:0] sh_r;
   reg done;
   reg bad;
   always @* begin
      done = enable && os_tick && st_r == STOP && ph_r == 4'hf;
      bad = done && !line_in;
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= IDLE;
         ph_r <= 4'h0;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         avail_r <= 1'b0;
         data_r <= 8'h00;
         ferr_r <= 1'b0;
         oerr_r <= 1'b0;
      end else if (soft_rst) begin
         st_r <= IDLE;
         avail_r <= 1'b0;
         ferr_r <= 1'b0;
         oerr_r <= 1'b0;
      end else begin
         // Set wins over clear so an error is never lost
         ferr_r <= bad | (ferr_r & ~err_clr);
         oerr_r <= (done & avail_r & ~rd_take) | (oerr_r & ~err_clr);
         if (done) begin
            data_r <= sh_r;
            avail_r <= 1'b1;
         end else if (rd_take) begin
            avail_r <= 1'b0;
         end
         if (!enable) begin
            st_r <= IDLE;
         end else if (os_tick) begin
            ph_r <= ph_r + 4'h1;
            case (st_r)
               IDLE: begin
                  ph_r <= 4'h0;
                  if (!line_in) begin
                     st_r <= BITS;
                     cnt_r <= 4'h0;
                     ph_r <= 4'h8;
                  end
               end
               BITS: if (ph_r == 4'hf) begin
                  if (cnt_r != 4'h0) begin
                     sh_r <= {line_in, sh_r[7:1]};
                  end
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == 4'h8) begin
                     st_r <= STOP;
                  end
               end
               STOP: if (ph_r == 4'hf) begin
                  st_r <= IDLE;
               end
               default: st_r <= IDLE;
            endcase
         end
      end
   end
endmodule

// ===== tb/qas_chk_sva.sv
// Checker for qas_top: read path, ready pins and line idle.
// Assumes one clock domain and a bind onto qas_top.
`timescale 1ns/1ps
module qas_chk (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Host bus
   input wire cs,
   input wire cmd_sel,
   input wire [2:0] addr,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] wdata,
   input wire [7:0] rdata_r,
   input wire rx_ready_irq_n,
   input wire tx_ready_irq_n,
   // Serial
   input wire [3:0] serial_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire wr = cs && wr_stb;
   wire rd = cs && rd_stb;
   reg [7:0] msk_r;
   reg ini_r;
   reg ini2_r;
   // ==========
   // Shadow of the mask, cleared with the initial reset
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         msk_r <= 8'h00;
         ini_r <= 1'b0;
         ini2_r <= 1'b0;
      end else begin
         ini_r <= wr && cmd_sel && addr == 3'h1 && wdata[7];
         ini2_r <= ini_r;
         if (ini_r)
            msk_r <= 8'h00;
         else if (wr && cmd_sel && addr == 3'h0)
            msk_r <= wdata;
      end
   end
   // ==========
   // Assertions
   a_reset_idle: assert property (
      $fell(rst) |-> serial_out == 4'hf && rx_ready_irq_n && tx_ready_irq_n)
      else $error("outputs busy after reset");
   a_rdata_hold: assert property (
      !rd && !ini_r && !$past(ini_r) |=> $stable(rdata_r))
      else $error("read data moved");
   a_unused_zero: assert property (
      rd && cmd_sel && addr == 3'h7 |=> rdata_r == 8'h00)
      else $error("unused code read");
   a_data_gap: assert property (
      rd && !cmd_sel && addr[2] |=> rdata_r == 8'h00)
      else $error("data gap read");
   a_mask_read: assert property (
      rd && cmd_sel && addr == 3'h0 |=> rdata_r == $past(msk_r))
      else $error("mask readback");
   a_tx_masked: assert property (
      msk_r[3:0] == 4'hf |=> tx_ready_irq_n)
      else $error("tx ready while masked");
   a_rx_masked: assert property (
      msk_r[7:4] == 4'hf |=> rx_ready_irq_n)
      else $error("rx ready while masked");
   // Abort by initial reset may cut a start bit short
   a_start_len: assert property (disable iff (rst || ini_r || ini2_r)
      $fell(serial_out[2]) |-> (serial_out[2] == 1'b0) [*8])
      else $error("start bit too short");
   c_data_read: cover property (rd && !cmd_sel && !addr[2]);
   c_err_read: cover property (rd && cmd_sel && addr == 3'h6);
   c_frame: cover property ($fell(serial_out[2]));
endmodule
bind qas_top qas_chk chk_u (.*);

// ===== tb/qas_peer.sv
// Far-end serial peer: sends frames to receive pins, catches frames.
// Assumes the bit length in clk_sys cycles is given at each call.
`timescale 1ns/1ps
module qas_peer (
   // Clock
   input wire clk_sys,
   // Serial lines, index 3 = physical A
   input wire [3:0] tx,
   output reg [3:0] line_r
);
   integer k;
   // Mark level between frames, as on a pulled-up line
   initial line_r = 4'hf;
   task send(input integer p, input [7:0] b, input integer bt, input stp);
      reg [9:0] f;
      begin
         f = {stp, b, 1'b0};
         for (k = 0; k < 10; k = k + 1) begin
            line_r[p] <= f[k];
            repeat (bt) @(posedge clk_sys);
         end
         // One idle cycle so back-to-back calls never drive twice at once
         line_r[p] <= 1'b1;
         @(posedge clk_sys);
      end
   endtask
   task catch(input integer p, input integer bt, output [7:0] b, output stp);
      integer n;
      begin
         n = 0;
         while (tx[p] !== 1'b0 && n < 4000) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         repeat (bt / 2) @(posedge clk_sys);
         for (k = 0; k < 8; k = k + 1) begin
            repeat (bt) @(posedge clk_sys);
            b[k] = tx[p];
         end
         repeat (bt) @(posedge clk_sys);
         stp = tx[p];
      end
   endtask
endmodule

// ===== tb/test_quad_async_serial_regs.sv
// Testbench for qas_top: registers, mapping, rates, frames, errors.
// Assumes qas_peer drives receive pins and catches transmit frames.
`timescale 1ns/1ps
module test_quad_async_serial_regs;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg cs = 1'b0;
   reg cmd_sel = 1'b0;
   reg [2:0] addr = 3'h0;
   reg wr_stb = 1'b0;
   reg rd_stb = 1'b0;
   reg [7:0] wdata = 8'h00;
   reg [3:0] hw_rate_preset_en = 4'hf;
   reg [11:0] hw_rate_code = 12'h000;
   wire [7:0] rdata_r;
   wire rx_ready_irq_n;
   wire tx_ready_irq_n;
   wire [3:0] serial_in;
   wire [3:0] serial_out;
   integer miscompares = 0;
   integer checks_done = 0;
   integer i;
   reg [7:0] v;
   reg [7:0] d;
   reg [2:0] a;
   reg s;
   always #5 clk_sys = ~clk_sys;
   qas_top #(.BASE_DIV(2)) dut_u (.*);
   qas_peer peer_u (.clk_sys(clk_sys), .tx(serial_out), .line_r(serial_in));
   // ==========
   // Expectation and bus helpers
   function integer blen(input [2:0] c);
      blen = 16 * 2 * (1 << c);
   endfunction
   task give_verdict;
      begin
         if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk8(input [7:0] g, input [7:0] e);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task chk1(input g, input e);
      begin
         chk8({7'h00, g}, {7'h00, e});
      end
   endtask
   task wr(input c, input [2:0] ad, input [7:0] w);
      begin
         @(posedge clk_sys);
         cs <= 1'b1;
         cmd_sel <= c;
         addr <= ad;
         wdata <= w;
         wr_stb <= 1'b1;
         @(posedge clk_sys);
         cs <= 1'b0;
         wr_stb <= 1'b0;
      end
   endtask
   task rd(input c, input [2:0] ad, output [7:0] r);
      begin
         @(posedge clk_sys);
         cs <= 1'b1;
         cmd_sel <= c;
         addr <= ad;
         rd_stb <= 1'b1;
         @(posedge clk_sys);
         cs <= 1'b0;
         rd_stb <= 1'b0;
         @(posedge clk_sys);
         #1 r = rdata_r;
      end
   endtask
   task rc(input c, input [2:0] ad, input [7:0] e);
      begin
         rd(c, ad, d);
         chk8(d, e);
      end
   endtask
   // ==========
   // Main sequence
   initial begin
      v = $urandom(32'he49223c8);
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rc(1, 0, 8'h00);
      rc(1, 2, 8'he4);
      rc(1, 3, 8'h00);
      rc(1, 4, 8'h00);
      rc(1, 6, 8'h00);
      for (i = 0; i < 12; i = i + 1) begin
         v = $urandom;
         a = i[1:0] == 2'h1 ? 3'h4 : {1'b0, i[1:0]};
         wr(1, a, v);
         wr(1, 3'h7, ~v);
         wr(1, 3'h5, ~v);
         rc(1, a, v);
      end
      rc(1, 7, 8'h00);
      wr(1, 0, 8'h5a);
      wr(1, 1, 8'h0f);
      rc(1, 0, 8'h5a);
      wr(1, 1, 8'h80);
      repeat (2) @(posedge clk_sys);
      rc(1, 0, 8'h00);
      rc(1, 2, 8'he4);
      // Swap A and B so mapping errors show on the wrong line
      wr(1, 2, 8'hb4);
      for (i = 0; i < 4; i = i + 1) begin
         // Last pass: preset code 3 overrides software code 2 on physical B
         wr(1, 3, {5'h11, (i == 3) ? 3'h2 : i[2:0]});
         hw_rate_preset_en <= (i == 3) ? 4'hb : 4'hf;
         hw_rate_code <= 12'h0c0;
         v = $urandom;
         wr(0, 0, v);
         rd(1, 5, d);
         chk1(d[3], 1'b0);
         peer_u.catch(2, blen(i), d, s);
         chk8(d, v);
         chk1(s, 1'b1);
         chk1(serial_out[3], 1'b1);
         repeat (blen(i)) @(posedge clk_sys);
         rd(1, 5, d);
         chk1(d[3], 1'b1);
      end
      hw_rate_preset_en <= 4'hf;
      v = $urandom;
      peer_u.send(2, v, blen(2), 1'b1);
      repeat (blen(2)) @(posedge clk_sys);
      rd(1, 5, d);
      chk1(d[7], 1'b1);
      chk1(rx_ready_irq_n, 1'b0);
      wr(1, 0, 8'hf0);
      repeat (2) @(posedge clk_sys);
      chk1(rx_ready_irq_n, 1'b1);
      wr(1, 0, 8'h00);
      rc(0, 0, v);
      repeat (2) @(posedge clk_sys);
      chk1(rx_ready_irq_n, 1'b1);
      peer_u.send(2, v, blen(2), 1'b0);
      repeat (blen(2)) @(posedge clk_sys);
      rd(1, 6, d);
      chk1(d[7], 1'b1);
      rd(0, 0, d);
      // Low stop bit looks like a new start; let that ghost frame finish and drain it
      repeat (blen(2) * 10) @(posedge clk_sys);
      rd(0, 0, d);
      peer_u.send(2, ~v, blen(2), 1'b1);
      peer_u.send(2, v, blen(2), 1'b1);
      repeat (blen(2)) @(posedge clk_sys);
      rc(1, 6, 8'h88);
      wr(1, 1, 8'h04);
      rc(1, 6, 8'h88);
      wr(1, 1, 8'h08);
      repeat (2) @(posedge clk_sys);
      rc(1, 6, 8'h00);
      rc(0, 0, v);
      give_verdict;
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      miscompares = miscompares + 1;
      give_verdict;
   end
endmodule
